// ===== rtl/rssr_defines.vh
// Purpose: offsets, field positions, reset values and codes of the sensor register bank
// Assumes: 16-bit registers behind an 8-bit register pointer
// Notes: included by the register bank only
`ifndef RSSR_DEFINES_VH
`define RSSR_DEFINES_VH

`define RSSR_OFF_ROT 8'h12
`define RSSR_OFF_TOUCH 8'h13
`define RSSR_OFF_COAST 8'h14
`define RSSR_OFF_SYS 8'h60
`define RSSR_OFF_BUS 8'h61

`define RSSR_SYS_RESET 16'h6911
`define RSSR_SYS_WMASK 16'h7fbf
`define RSSR_SYS_OSC_MASK 16'h0080
`define RSSR_BUS_RESET 16'h0000
`define RSSR_BUS_WMASK 16'h0003

`define RSSR_SYS_SLEEP_EN 14
`define RSSR_SYS_EVENT 13
`define RSSR_SYS_MODE_HI 12
`define RSSR_SYS_MODE_LO 8
`define RSSR_SYS_OSC 7
`define RSSR_SYS_TALK 5
`define RSSR_SYS_RT_TUNE 4
`define RSSR_SYS_ACK 3
`define RSSR_SYS_SOFT 2
`define RSSR_SYS_TUNE 1
`define RSSR_SYS_STREAM 0
`define RSSR_BUS_NOCHECK 1
`define RSSR_BUS_KEEPOPEN 0

`define RSSR_MODE_HA 5'h00
`define RSSR_MODE_NORMAL 5'h01
`define RSSR_MODE_LOW 5'h02
`define RSSR_MODE_SLEEP 5'h04
`define RSSR_MODE_HALT 5'h08
`define RSSR_MODE_AUTO 5'h09

`define RSSR_CMD_END 8'hff

`endif

// ===== rtl/rssr_regs.v
// Purpose: status and settings register bank reached over an I2C slave port
// Assumes: status inputs come from sensing logic on core_clk; scl and sda are pins
// Notes: words go low byte first; the pointer advances after each written word and after each read word whose high byte the host acknowledges
`default_nettype none
`include "rssr_defines.vh"

module rssr_regs #(
  parameter [6:0] DEV_ADDR = 7'h2a,
  parameter HAS_EXTRAS = 1
) (
  input wire core_clk,
  input wire arst_n,
  input wire scl_in,
  input wire sda_in,
  output reg sda_out,
  output reg sda_oe,
  input wire fast_filter_active,
  input wire low_field_detect,
  input wire stationary_detect,
  input wire direction_forward,
  input wire interval_change,
  input wire tune_done,
  input wire tune_failed,
  input wire touch_debounce,
  input wire delta_positive,
  input wire dormancy_timeout,
  input wire touch_active,
  input wire prox_active,
  input wire coast_touch_exit,
  input wire coast_touch_enter,
  input wire coast_active,
  input wire [4:0] auto_mode_request,
  output reg [4:0] power_mode_now,
  output reg channel_dormant,
  output reg window_open,
  output reg tune_start,
  output reg soft_reset_pulse,
  output reg reset_flag,
  output reg event_mode,
  output reg streaming_mode,
  output reg osc_slow_select,
  output reg runtime_tune_enable
);
  localparam [3:0] ST_IDLE = 4'h0;
  localparam [3:0] ST_ADDR = 4'h1;
  localparam [3:0] ST_AACK = 4'h2;
  localparam [3:0] ST_REG = 4'h3;
  localparam [3:0] ST_WDATA = 4'h4;
  localparam [3:0] ST_WACK = 4'h5;
  localparam [3:0] ST_RDATA = 4'h6;
  localparam [3:0] ST_RACK = 4'h7;
  localparam [15:0] SYS_MASK = HAS_EXTRAS ? `RSSR_SYS_WMASK : (`RSSR_SYS_WMASK & ~`RSSR_SYS_OSC_MASK);

  reg rst_ff1;
  reg rst_n;
  wire [1:0] pins_s;
  reg scl_d;
  reg sda_d;
  reg [3:0] state;
  reg [3:0] cnt;
  reg [7:0] shreg;
  reg [7:0] ptr;
  reg [7:0] lo_buf;
  reg [15:0] rd_word;
  reg byte_hi;
  reg rd_mode;
  reg mst_nack;
  reg wnack;
  reg wr_en;
  reg [7:0] wr_ptr;
  reg [15:0] wr_data;
  reg clr_rot;
  reg clr_coast;
  reg [15:0] sys;
  reg [15:0] bus;
  reg tune_busy;
  reg interval_flag;
  reg exit_flag;
  reg enter_flag;
  reg coast_still;
  reg tune_error;

  // reset is released through two flops so that all flops leave reset together
  always @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      rst_ff1 <= 1'b0;
      rst_n <= 1'b0;
    end else begin
      rst_ff1 <= 1'b1;
      rst_n <= rst_ff1;
    end
  end

  rssr_sync #(
    .W(2)
  ) u_pin_sync (
    .clk(core_clk),
    .rst_n(rst_n),
    .d({scl_in, sda_in}),
    .q(pins_s)
  );

  wire scl_s = pins_s[1];
  wire sda_s = pins_s[0];
  wire scl_rise = scl_s & ~scl_d;
  wire scl_fall = ~scl_s & scl_d;
  wire start_det = scl_s & scl_d & sda_d & ~sda_s;
  wire stop_det = scl_s & scl_d & ~sda_d & sda_s;
  wire talk_ok = sys[`RSSR_SYS_TALK] | ~tune_busy;
  wire extra = (HAS_EXTRAS != 0);

  function writable;
    input [7:0] p;
    begin
      writable = (p == `RSSR_OFF_SYS) || (p == `RSSR_OFF_BUS);
    end
  endfunction

  // reserved bits are constant zero in every word
  function [15:0] read_word;
    input [7:0] p;
    begin
      case (p)
        `RSSR_OFF_ROT: read_word = {10'h000, fast_filter_active, low_field_detect & extra,
          power_mode_now == `RSSR_MODE_HA, stationary_detect,
          direction_forward, interval_flag};
        `RSSR_OFF_TOUCH: read_word = {4'h0, tune_error & extra, touch_debounce, delta_positive,
          channel_dormant, 6'h00, touch_active, prox_active};
        `RSSR_OFF_COAST: read_word = {12'h000, exit_flag, enter_flag, coast_still, coast_active};
        `RSSR_OFF_SYS: read_word = sys;
        `RSSR_OFF_BUS: read_word = bus;
        default: read_word = 16'h0000;
      endcase
    end
  endfunction

  wire [15:0] cur_word = read_word(ptr);
  wire [7:0] ptr_inc = ptr + 8'h01;
  wire [15:0] next_word = read_word(ptr_inc);
  wire [7:0] tx_byte = byte_hi ? rd_word[15:8] : rd_word[7:0];
  wire tx_bit = tx_byte[3'h7 - cnt[2:0]];

  always @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      scl_d <= 1'b1;
      sda_d <= 1'b1;
      state <= ST_IDLE;
      cnt <= 4'h0;
      shreg <= 8'h00;
      ptr <= 8'h00;
      lo_buf <= 8'h00;
      rd_word <= 16'h0000;
      byte_hi <= 1'b0;
      rd_mode <= 1'b0;
      mst_nack <= 1'b0;
      wnack <= 1'b0;
      wr_en <= 1'b0;
      wr_ptr <= 8'h00;
      wr_data <= 16'h0000;
      clr_rot <= 1'b0;
      clr_coast <= 1'b0;
      sda_out <= 1'b0;
      sda_oe <= 1'b0;
      window_open <= 1'b0;
    end else begin
      scl_d <= scl_s;
      sda_d <= sda_s;
      wr_en <= 1'b0;
      clr_rot <= 1'b0;
      clr_coast <= 1'b0;
      if (start_det) begin
        state <= ST_ADDR;
        cnt <= 4'h0;
        sda_oe <= 1'b0;
      end else if (stop_det) begin
        state <= ST_IDLE;
        sda_oe <= 1'b0;
        if (!bus[`RSSR_BUS_KEEPOPEN]) begin
          window_open <= 1'b0;
        end
      end else if (scl_rise) begin
        case (state)
          ST_ADDR, ST_REG, ST_WDATA: begin
            shreg <= {shreg[6:0], sda_s};
            cnt <= cnt + 4'h1;
          end
          ST_RACK: mst_nack <= sda_s;
          default: ;
        endcase
      end else if (scl_fall) begin
        case (state)
          ST_ADDR: begin
            if (cnt == 4'h8) begin
              if (shreg[7:1] == DEV_ADDR && talk_ok) begin
                rd_mode <= shreg[0];
                sda_oe <= 1'b1;
                window_open <= 1'b1;
                state <= ST_AACK;
              end else begin
                state <= ST_IDLE;
              end
            end
          end
          ST_AACK: begin
            cnt <= rd_mode ? 4'h1 : 4'h0;
            if (rd_mode) begin
              rd_word <= cur_word;
              byte_hi <= 1'b0;
              clr_rot <= (ptr == `RSSR_OFF_ROT);
              clr_coast <= (ptr == `RSSR_OFF_COAST);
              sda_oe <= ~cur_word[7];
              state <= ST_RDATA;
            end else begin
              sda_oe <= 1'b0;
              state <= ST_REG;
            end
          end
          ST_REG: begin
            if (cnt == 4'h8) begin
              cnt <= 4'h0;
              sda_oe <= 1'b1;
              wnack <= 1'b0;
              state <= ST_WACK;
              if (shreg == `RSSR_CMD_END) begin
                window_open <= 1'b0;
              end else begin
                ptr <= shreg;
                byte_hi <= 1'b0;
              end
            end
          end
          ST_WDATA: begin
            if (cnt == 4'h8) begin
              cnt <= 4'h0;
              state <= ST_WACK;
              // with the check on, words aimed at read-only places are refused
              sda_oe <= writable(ptr) | bus[`RSSR_BUS_NOCHECK];
              wnack <= ~(writable(ptr) | bus[`RSSR_BUS_NOCHECK]);
              if (!byte_hi) begin
                lo_buf <= shreg;
                byte_hi <= 1'b1;
              end else begin
                wr_en <= writable(ptr);
                wr_ptr <= ptr;
                wr_data <= {shreg, lo_buf};
                ptr <= ptr_inc;
                byte_hi <= 1'b0;
              end
            end
          end
          ST_WACK: begin
            sda_oe <= 1'b0;
            state <= wnack ? ST_IDLE : ST_WDATA;
          end
          ST_RDATA: begin
            if (cnt == 4'h8) begin
              sda_oe <= 1'b0;
              state <= ST_RACK;
            end else begin
              sda_oe <= ~tx_bit;
              cnt <= cnt + 4'h1;
            end
          end
          ST_RACK: begin
            if (mst_nack) begin
              state <= ST_IDLE;
            end else begin
              cnt <= 4'h1;
              state <= ST_RDATA;
              if (byte_hi) begin
                ptr <= ptr_inc;
                byte_hi <= 1'b0;
                rd_word <= next_word;
                clr_rot <= (ptr_inc == `RSSR_OFF_ROT);
                clr_coast <= (ptr_inc == `RSSR_OFF_COAST);
                sda_oe <= ~next_word[7];
              end else begin
                byte_hi <= 1'b1;
                sda_oe <= ~rd_word[15];
              end
            end
          end
          default: state <= ST_IDLE;
        endcase
      end
    end
  end

  // settings registers and their self-clearing commands
  always @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      sys <= `RSSR_SYS_RESET;
      bus <= `RSSR_BUS_RESET;
      tune_busy <= 1'b0;
      tune_start <= 1'b0;
      soft_reset_pulse <= 1'b0;
      reset_flag <= 1'b1;
    end else begin
      tune_start <= 1'b0;
      soft_reset_pulse <= 1'b0;
      sys[`RSSR_SYS_ACK] <= 1'b0;
      sys[`RSSR_SYS_SOFT] <= 1'b0;
      if (tune_done) begin
        sys[`RSSR_SYS_TUNE] <= 1'b0;
        tune_busy <= 1'b0;
      end
      if (wr_en && wr_ptr == `RSSR_OFF_SYS) begin
        if (wr_data[`RSSR_SYS_SOFT]) begin
          // soft reset puts every setting back to its default
          sys <= `RSSR_SYS_RESET | 16'h0004;
          bus <= `RSSR_BUS_RESET;
          soft_reset_pulse <= 1'b1;
          reset_flag <= 1'b1;
        end else begin
          sys <= wr_data & SYS_MASK;
          if (wr_data[`RSSR_SYS_ACK]) begin
            reset_flag <= 1'b0;
          end
          if (wr_data[`RSSR_SYS_TUNE]) begin
            tune_start <= 1'b1;
            tune_busy <= 1'b1;
          end
        end
      end else if (wr_en && wr_ptr == `RSSR_OFF_BUS) begin
        bus <= wr_data & `RSSR_BUS_WMASK;
      end
    end
  end

  always @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      event_mode <= 1'b1;
      streaming_mode <= 1'b1;
      osc_slow_select <= 1'b0;
      runtime_tune_enable <= 1'b1;
    end else begin
      event_mode <= sys[`RSSR_SYS_EVENT];
      streaming_mode <= sys[`RSSR_SYS_STREAM];
      osc_slow_select <= sys[`RSSR_SYS_OSC] & extra;
      runtime_tune_enable <= sys[`RSSR_SYS_RT_TUNE];
    end
  end

  // sticky flags: an event in the cycle of a read-clear still wins
  always @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      interval_flag <= 1'b0;
      exit_flag <= 1'b0;
      enter_flag <= 1'b0;
      coast_still <= 1'b0;
      tune_error <= 1'b0;
      channel_dormant <= 1'b0;
    end else begin
      interval_flag <= interval_change | (interval_flag & ~clr_rot);
      exit_flag <= coast_touch_exit | (exit_flag & ~clr_coast);
      enter_flag <= coast_touch_enter | (enter_flag & ~clr_coast);
      // only real rotation ends the still state, never a coasting step
      if (stationary_detect) begin
        coast_still <= 1'b1;
      end else if (interval_change) begin
        coast_still <= 1'b0;
      end
      if (tune_done) begin
        tune_error <= tune_failed;
      end
      if (dormancy_timeout) begin
        channel_dormant <= 1'b1;
      end else if (touch_active) begin
        channel_dormant <= 1'b0;
      end
    end
  end

  wire [4:0] mode_field = sys[`RSSR_SYS_MODE_HI:`RSSR_SYS_MODE_LO];

  function mode_valid;
    input [4:0] m;
    begin
      mode_valid = (m == `RSSR_MODE_HA) || (m == `RSSR_MODE_NORMAL) || (m == `RSSR_MODE_LOW) ||
        (m == `RSSR_MODE_SLEEP) || (m == `RSSR_MODE_HALT);
    end
  endfunction

  // undefined field codes leave the running mode unchanged
  always @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      power_mode_now <= `RSSR_MODE_HA;
    end else if (mode_field == `RSSR_MODE_AUTO) begin
      if (power_mode_now == `RSSR_MODE_SLEEP && !touch_active) begin
        power_mode_now <= `RSSR_MODE_SLEEP;
      end else if (auto_mode_request == `RSSR_MODE_SLEEP) begin
        power_mode_now <= sys[`RSSR_SYS_SLEEP_EN] ? `RSSR_MODE_SLEEP : `RSSR_MODE_LOW;
      end else if (mode_valid(auto_mode_request) && auto_mode_request != `RSSR_MODE_HALT) begin
        power_mode_now <= auto_mode_request;
      end
    end else if (mode_valid(mode_field)) begin
      power_mode_now <= mode_field;
    end
  end
endmodule
`default_nettype wire

// ===== rtl/rssr_sync.v
// Purpose: two-flop synchroniser for pin inputs
// Assumes: inputs idle high, so the flops reset to one
// Notes: only the second stage is visible
`default_nettype none
module rssr_sync #(
  parameter W = 2
) (
  input wire clk,
  input wire rst_n,
  input wire [W-1:0] d,
  output reg [W-1:0] q
);
  reg [W-1:0] meta;

  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      meta <= {W{1'b1}};
      q <= {W{1'b1}};
    end else begin
      meta <= d;
      q <= meta;
    end
  end
endmodule
`default_nettype wire

// ===== verification/rssr_host.sv
// Purpose: I2C host model for the sensor register bank
// Assumes: SDA has a pull-up; SCL period is 8 core_clk cycles (200 ns)
// Notes: clock stands high between frames
`default_nettype none
module rssr_host (
  input wire logic core_clk,
  input wire logic sda_w,
  output var logic scl,
  output var logic sda_m
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    scl = 1'b1;
    sda_m = 1'b1;
  end
  // data moves one cycle after the clock falls, so a data bit never looks like a start or stop
  task automatic ph(input logic a, input logic b, input logic fall, output logic r);
    repeat (1) @(posedge core_clk);
    sda_m <= a;
    repeat (3) @(posedge core_clk);
    scl <= 1'b1;
    repeat (2) @(posedge core_clk);
    r = sda_w;
    sda_m <= b;
    repeat (2) @(posedge core_clk);
    if (fall) scl <= 1'b0;
  endtask
  task automatic start();
    logic r;
    ph(1'b1, 1'b0, 1'b1, r);
  endtask
  task automatic stop();
    logic r;
    ph(1'b0, 1'b1, 1'b0, r);
  endtask
  task automatic wb(input logic [7:0] d, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) ph(d[i], d[i], 1'b1, r);
    ph(1'b1, 1'b1, 1'b1, r);
    ack = ~r;
  endtask
  task automatic rb(input logic last, output logic [7:0] d);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      ph(1'b1, 1'b1, 1'b1, r);
      d = {d[6:0], r};
    end
    ph(last, last, 1'b1, r);
  endtask
endmodule
`default_nettype wire

// ===== verification/rssr_regs_asserts.sv
// Purpose: port-level checks of the sensor register bank
// Assumes: bound to every instance of the bank
// Notes: one clock domain, so default clocking and disable are used
`default_nettype none
module rssr_regs_asserts (
  input wire logic core_clk,
  input wire logic arst_n,
  input wire logic scl_in,
  input wire logic sda_out,
  input wire logic sda_oe,
  input wire logic dormancy_timeout,
  input wire logic touch_active,
  input wire logic [4:0] power_mode_now,
  input wire logic channel_dormant,
  input wire logic window_open,
  input wire logic tune_start,
  input wire logic soft_reset_pulse,
  input wire logic reset_flag,
  input wire logic event_mode,
  input wire logic streaming_mode,
  input wire logic osc_slow_select,
  input wire logic runtime_tune_enable
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge core_clk); endclocking
  default disable iff (!arst_n);
  sequence s_defaults;
    reset_flag && event_mode && streaming_mode && runtime_tune_enable && !osc_slow_select;
  endsequence
  a_reset_vals: assert property ($rose(arst_n) |-> s_defaults ##0 (power_mode_now == 5'h00 && !window_open))
    else $error("outputs wrong after reset release");
  a_tune_pulse: assert property (tune_start |=> !tune_start)
    else $error("tune start longer than one cycle");
  a_soft_restore: assert property (soft_reset_pulse |-> ##[1:3] s_defaults)
    else $error("soft reset did not restore settings");
  a_dormant_set: assert property (dormancy_timeout |=> channel_dormant)
    else $error("dormancy timeout did not make channel dormant");
  a_dormant_wake: assert property (channel_dormant && touch_active && !dormancy_timeout |=> !channel_dormant)
    else $error("touch did not clear dormancy");
  a_mode_legal: assert property (power_mode_now inside {5'h00, 5'h01, 5'h02, 5'h04, 5'h08})
    else $error("power mode code outside the table");
  a_sleep_hold: assert property (power_mode_now == 5'h04 && !touch_active && !window_open |=> power_mode_now == 5'h04)
    else $error("deepest sleep left without touch");
  a_window_ack: assert property ($rose(window_open) |-> sda_oe || $past(sda_oe))
    else $error("window opened without address acknowledge");
  a_pin_steady: assert property (scl_in && $past(scl_in) |-> $stable(sda_oe) && !sda_out)
    else $error("data pin moved while clock high");
endmodule
bind rssr_regs rssr_regs_asserts u_chk (
  .core_clk(core_clk), .arst_n(arst_n), .scl_in(scl_in), .sda_out(sda_out), .sda_oe(sda_oe),
  .dormancy_timeout(dormancy_timeout), .touch_active(touch_active), .power_mode_now(power_mode_now),
  .channel_dormant(channel_dormant), .window_open(window_open), .tune_start(tune_start),
  .soft_reset_pulse(soft_reset_pulse), .reset_flag(reset_flag), .event_mode(event_mode),
  .streaming_mode(streaming_mode), .osc_slow_select(osc_slow_select), .runtime_tune_enable(runtime_tune_enable));
`default_nettype wire

// ===== verification/rssr_regs_tb.sv
// Purpose: self-checking bench of the sensor register bank
// Assumes: default device address; bench host model drives the pins
// Notes: expected values queue up, a watcher compares each result
`default_nettype none
`define CHK(a, e) begin samples_checked++; if ((a) !== (e)) begin miscompares++; \
  $display("CHECK FAILED t=%0t got=%h exp=%h", $time, a, e); end end
module rssr_regs_tb;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [6:0] DEV = 7'h2a;
  logic core_clk = 1'b0;
  logic arst_n = 1'b0;
  logic [9:0] lv = '0;
  logic [4:0] pl = '0;
  logic [4:0] amr = '0;
  logic scl, sda_m, sda_oe, sda_out, channel_dormant, window_open, tune_start, soft_reset_pulse, reset_flag;
  logic event_mode, streaming_mode, osc_slow_select, runtime_tune_enable;
  logic [4:0] power_mode_now;
  wire logic sda_w = sda_m & ~(sda_oe & ~sda_out);
  logic [15:0] exp_q[$];
  logic [15:0] got = '0;
  logic [15:0] ew, v, rv;
  logic got_vld = 1'b0;
  logic k, kx, cs, ic, ex, en;
  int miscompares = 0;
  int samples_checked = 0;
  int cyc = 0;
  int seed = 32'hbf11;
  logic [4:0] md [6] = '{5'h00, 5'h01, 5'h02, 5'h04, 5'h08, 5'h09};
  initial forever #12.5 core_clk = ~core_clk;
  rssr_host host (.core_clk(core_clk), .sda_w(sda_w), .scl(scl), .sda_m(sda_m));
  rssr_regs uut (
    .core_clk(core_clk), .arst_n(arst_n), .scl_in(scl), .sda_in(sda_w), .sda_out(sda_out), .sda_oe(sda_oe),
    .fast_filter_active(lv[0]), .low_field_detect(lv[1]), .stationary_detect(lv[2]), .direction_forward(lv[3]),
    .interval_change(pl[0]), .tune_done(pl[1]), .tune_failed(lv[4]), .touch_debounce(lv[5]),
    .delta_positive(lv[6]), .dormancy_timeout(pl[2]), .touch_active(lv[7]), .prox_active(lv[8]),
    .coast_touch_exit(pl[3]), .coast_touch_enter(pl[4]), .coast_active(lv[9]), .auto_mode_request(amr),
    .power_mode_now(power_mode_now), .channel_dormant(channel_dormant), .window_open(window_open),
    .tune_start(tune_start), .soft_reset_pulse(soft_reset_pulse), .reset_flag(reset_flag),
    .event_mode(event_mode), .streaming_mode(streaming_mode), .osc_slow_select(osc_slow_select),
    .runtime_tune_enable(runtime_tune_enable));
  task automatic end_of_test();
    if (miscompares == 0 && samples_checked > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  task automatic res(input logic [15:0] a);
    got <= a;
    got_vld <= 1'b1;
    @(posedge core_clk);
    got_vld <= 1'b0;
    @(posedge core_clk);
  endtask
  task automatic chk_o(input logic [15:0] e, input logic [15:0] a);
    exp_q.push_back(e);
    res(a);
  endtask
  // k keeps the answer to the low data byte, where a refused write shows
  task automatic wr(input logic [7:0] p, input logic [15:0] d);
    host.start();
    host.wb({DEV, 1'b0}, kx);
    host.wb(p, kx);
    host.wb(d[7:0], k);
    host.wb(d[15:8], kx);
    host.stop();
    repeat (4) @(posedge core_clk);
  endtask
  task automatic rd(input logic [7:0] p, input logic [15:0] e);
    exp_q.push_back(e);
    host.start();
    host.wb({DEV, 1'b0}, kx);
    host.wb(p, kx);
    host.start();
    host.wb({DEV, 1'b1}, kx);
    host.rb(1'b0, v[7:0]);
    host.rb(1'b1, v[15:8]);
    host.stop();
    res(v);
  endtask
  always @(posedge core_clk) begin
    if (got_vld === 1'b1) begin
      ew = exp_q.pop_front();
      `CHK(got, ew)
    end
  end
  always @(posedge core_clk) begin
    cyc++;
    if (cyc == 40000) begin
      miscompares++;
      end_of_test();
    end
  end
  initial begin
    repeat (5) @(posedge core_clk);
    arst_n <= 1'b1;
    repeat (8) @(posedge core_clk);
    rd(8'h60, 16'h6911);
    rd(8'h61, 16'h0000);
    cs = 1'b0;
    for (int i = 0; i < 4; i++) begin
      rv = $random(seed);
      rv[2] = rv[2] | (i == 0);
      {en, ex, ic} = rv[13:11];
      lv <= rv[9:0];
      amr <= {4'h0, rv[10]};
      @(posedge core_clk);
      pl <= {4'h0, ic};
      @(posedge core_clk);
      pl <= {en, ex, 3'b110};
      @(posedge core_clk);
      pl <= 5'h00;
      repeat (6) @(posedge core_clk);
      // coast stationary survives until an interval change with the detector low
      cs = rv[2] | (cs & ~ic);
      rd(8'h12, {10'h0, rv[0], rv[1], ~rv[10], rv[2], rv[3], ic});
      rd(8'h12, {10'h0, rv[0], rv[1], ~rv[10], rv[2], rv[3], 1'b0});
      rd(8'h13, {4'h0, rv[4], rv[5], rv[6], ~rv[7], 6'h0, rv[7], rv[8]});
      rd(8'h14, {12'h0, ex, en, cs, rv[9]});
      rd(8'h14, {12'h0, 2'b00, cs, rv[9]});
    end
    // no watchdog lives in this bank, so halt is entered bare
    for (int i = 0; i < 6; i++) begin
      rv = $random(seed) & 16'he0f1;
      rv[12:8] = md[i];
      wr(8'h60, rv);
      chk_o({12'h0, rv[13], rv[0], rv[7], rv[4]}, {12'h0, event_mode, streaming_mode, osc_slow_select,
        runtime_tune_enable});
      if (i < 5) chk_o({11'h0, md[i]}, {11'h0, power_mode_now});
      rd(8'h60, rv & 16'h7fbf);
    end
    lv <= 10'h000;
    amr <= 5'h04;
    wr(8'h60, 16'h6911);
    chk_o(16'h0004, {11'h0, power_mode_now});
    amr <= 5'h01;
    repeat (8) @(posedge core_clk);
    chk_o(16'h0004, {11'h0, power_mode_now});
    lv <= 10'h080;
    repeat (8) @(posedge core_clk);
    chk_o(16'h0001, {11'h0, power_mode_now});
    lv <= 10'h000;
    wr(8'h60, 16'h2911);
    amr <= 5'h04;
    repeat (8) @(posedge core_clk);
    chk_o(16'h0002, {11'h0, power_mode_now});
    wr(8'h60, 16'h6933);
    rd(8'h60, 16'h6933);
    pl <= 5'h02;
    @(posedge core_clk);
    pl <= 5'h00;
    repeat (2) @(posedge core_clk);
    rd(8'h60, 16'h6931);
    wr(8'h60, 16'h6939);
    chk_o(16'h0000, {15'h0, reset_flag});
    rd(8'h60, 16'h6931);
    // tuning busy with talk-while-tuning off: the address must go unanswered
    wr(8'h60, 16'h6913);
    host.start();
    host.wb({DEV, 1'b0}, k);
    host.stop();
    repeat (4) @(posedge core_clk);
    chk_o(16'h0000, {15'h0, k});
    pl <= 5'h02;
    @(posedge core_clk);
    pl <= 5'h00;
    repeat (2) @(posedge core_clk);
    rd(8'h60, 16'h6911);
    wr(8'h61, 16'h0002);
    wr(8'h60, 16'h0004);
    chk_o(16'h0001, {15'h0, reset_flag});
    rd(8'h60, 16'h6911);
    rd(8'h61, 16'h0000);
    wr(8'h12, 16'h1234);
    chk_o(16'h0000, {15'h0, k});
    wr(8'h61, 16'hfffe);
    rd(8'h61, 16'h0002);
    wr(8'h13, 16'h1234);
    chk_o(16'h0001, {15'h0, k});
    rd(8'h30, 16'h0000);
    chk_o(16'h0000, {15'h0, window_open});
    wr(8'h61, 16'h0001);
    chk_o(16'h0001, {15'h0, window_open});
    host.start();
    host.wb({DEV, 1'b0}, kx);
    host.wb(8'hff, kx);
    host.stop();
    repeat (4) @(posedge core_clk);
    chk_o(16'h0000, {15'h0, window_open});
    end_of_test();
  end
endmodule
`default_nettype wire
